// *** hdl/obcd_pkg.sv ***
// package: option byte map, field layout, defaults, carriers and decoder
package obcd_pkg;

  // register byte addresses on the avalon slave
  localparam logic [3:0] ADDR_OPT0 = 4'h0;
  localparam logic [3:0] ADDR_OPT1 = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;

  // option byte 1 field positions
  localparam int B1_STARTUP_CLOCK_SELECT_LSB = 6;
  localparam int B1_RSVD      = 5;
  localparam int B1_PLL       = 4;
  localparam int B1_LVD_LSB   = 2;
  localparam int B1_WDG_TYPE  = 1;
  localparam int B1_WATCHDOG_RESET_ON_HALT  = 0;

  // option byte 0 field positions
  localparam int B0_WAKE      = 7;
  localparam int B0_RANGE_LSB = 4;
  localparam int B0_SECT_LSB  = 2;
  localparam int B0_RDP       = 1;
  localparam int B0_WRP       = 0;

  // delivered / erased values
  localparam logic [7:0] OPT0_DEFAULT = 8'hFC;
  localparam logic [7:0] OPT1_DEFAULT = 8'h3F;
  localparam logic [7:0] PROG_FILL    = 8'hFF;

  // control and status bit positions
  localparam int CTRL_ERASE     = 0;
  localparam int CTRL_CLR_REFUS = 1;
  localparam int STAT_REFUSED   = 0;
  localparam int STAT_WP        = 1;
  localparam int STAT_RDP       = 2;
  localparam int STAT_WARN      = 3;
  localparam int STAT_ACT0_LSB  = 16;
  localparam int STAT_ACT1_LSB  = 24;

  // field codes
  localparam logic [1:0]  CLK_INT_RC     = 2'h0;
  localparam logic [1:0]  LVD_OFF        = 2'h3;
  localparam logic [2:0]  RANGE_VLP      = 3'h4;
  localparam logic [2:0]  RANGE_EXT_MAIN = 3'h5;
  localparam logic [2:0]  RANGE_RSVD     = 3'h6;
  localparam logic [2:0]  RANGE_EXT_ALT  = 3'h7;
  localparam logic [12:0] SECT_BASE_BYTE = 13'h0200;

  // avalon request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } obcd_avm_req_s;

  // decoded hardware settings
  typedef struct packed {
    logic [1:0]  startup_clock_select;
    logic        fast_pll_bypass;
    logic        pll_enable;
    logic        lvd_enable;
    logic [1:0]  low_voltage_detect_level;
    logic        watchdog_type_select;
    logic        watchdog_hw_on;
    logic        watchdog_reset_on_halt;
    logic        wakeup_clock_select;
    logic [2:0]  oscillator_range;
    logic        range_applies;
    logic        ext_clk_main_pin;
    logic        ext_clk_alt_pin;
    logic        range_reserved;
    logic [12:0] boot_sector_bytes;
    logic        readout_protect;
    logic        flash_write_protect;
    logic        prog_write_block;
  } obcd_cfg_s;

  // turns the two option bytes into settings
  function automatic obcd_cfg_s decode_cfg(input logic [7:0] b0, input logic [7:0] b1);
    obcd_cfg_s c;
    c = '0;
    c.startup_clock_select     = b1[B1_STARTUP_CLOCK_SELECT_LSB +: 2];
    c.fast_pll_bypass          = b1[B1_PLL];
    c.pll_enable               = ~b1[B1_PLL];
    c.low_voltage_detect_level = b1[B1_LVD_LSB +: 2];
    c.lvd_enable               = (b1[B1_LVD_LSB +: 2] != LVD_OFF);
    c.watchdog_type_select     = b1[B1_WDG_TYPE];
    c.watchdog_hw_on           = ~b1[B1_WDG_TYPE];
    c.watchdog_reset_on_halt   = b1[B1_WATCHDOG_RESET_ON_HALT];
    c.wakeup_clock_select      = b0[B0_WAKE];
    c.oscillator_range         = b0[B0_RANGE_LSB +: 3];
    c.range_applies            = b1[B1_STARTUP_CLOCK_SELECT_LSB + 1];
    c.ext_clk_main_pin         = c.range_applies && (b0[B0_RANGE_LSB +: 3] == RANGE_EXT_MAIN);
    c.ext_clk_alt_pin          = c.range_applies && (b0[B0_RANGE_LSB +: 3] == RANGE_EXT_ALT);
    c.range_reserved           = (b0[B0_RANGE_LSB +: 3] == RANGE_RSVD);
    c.boot_sector_bytes        = SECT_BASE_BYTE << b0[B0_SECT_LSB +: 2];
    c.readout_protect          = b0[B0_RDP];
    c.flash_write_protect      = b0[B0_WRP];
    c.prog_write_block         = b0[B0_RDP] | b0[B0_WRP];
    return c;
  endfunction

  localparam obcd_cfg_s CFG_RESET = decode_cfg(OPT0_DEFAULT, OPT1_DEFAULT);

endpackage

// *** hdl/obcd_nvstore.sv ***
// two-byte non-volatile option store with registered read data
`timescale 1ns/100ps
module obcd_nvstore (
  // clock and power-on
  input  wire logic       ref_clk_i,
  input  wire logic       por_b_i,
  // access port
  input  wire logic       addr_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);

  logic [7:0] cell_0;
  logic [7:0] cell_1;

  // only power-on restores the delivered state, system reset keeps contents
  always_ff @(posedge ref_clk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      cell_0  <= obcd_pkg::OPT0_DEFAULT;
      cell_1  <= obcd_pkg::OPT1_DEFAULT;
      rdata_o <= 8'h00;
    end else begin
      if (we_i && !addr_i) cell_0 <= wdata_i;
      if (we_i && addr_i) cell_1 <= wdata_i;
      rdata_o <= addr_i ? cell_1 : cell_0; // old data on a write cycle
    end
  end

endmodule

// *** hdl/obcd_top.sv ***
// option byte configuration decoder with avalon-mm register slave
// Function
// - option bytes reachable only in programming mode
// - byte1 bits 7:6 pick startup clock
// - default startup clock is internal rc
// - byte1 bit 4 one bypasses fast pll
// - byte1 bits 3:2 set lvd level, 11 off
// - byte1 bit 1 zero forces hardware watchdog
// - byte1 bit 0 resets on halt if watchdog
// - byte0 bit 7 picks auto-wakeup clock
// - range bits 6:4 apply when byte1 bit 7 set
// - range codes 100 to 111 decoded
// - byte0 bits 3:2 set boot sector size
// - readout protect blocks extraction and flash writes
// - erasing protected options first erases memory
// - byte0 bit 0 write protects program flash
// - write protect permanently refuses erase or program
// - erased program memory reads all ones
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module obcd_top (
  // clock and resets
  input  wire logic                ref_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                por_b_i,
  // avalon-mm register slave
  input  obcd_pkg::obcd_avm_req_s  avm_i,
  output logic              [31:0] avm_readdata_o,
  output logic                     avm_waitrequest_o,
  // device state inputs
  input  wire logic                prog_mode_i,
  input  wire logic                halt_entry_i,
  input  wire logic                sw_wdg_enable_i,
  input  wire logic                mass_erase_done_i,
  // decoded settings and actions
  output obcd_pkg::obcd_cfg_s      cfg_o,
  output logic                     halt_reset_o,
  output logic                     mass_erase_req_o,
  output logic               [7:0] erase_fill_o
);

  typedef enum logic [3:0] {
    ST_LOAD0,
    ST_LOAD1,
    ST_LOAD2,
    ST_IDLE,
    ST_ACC,
    ST_RESP,
    ST_MERASE,
    ST_OERASE0,
    ST_OERASE1
  } obcd_state_e;

  obcd_state_e state_q;
  obcd_state_e next_state;
  logic  [7:0] act0;
  logic  [7:0] act1;
  logic        wp_stored;
  logic        rdp_stored;
  logic        refused;
  logic        warn;
  logic        erase_pend;
  logic  [7:0] mem_rdata;
  logic [31:0] next_readdata;

  // address decode of the pending request
  wire       req_any   = avm_i.read | avm_i.write;
  wire       sel_opt0  = (avm_i.address == obcd_pkg::ADDR_OPT0);
  wire       sel_opt1  = (avm_i.address == obcd_pkg::ADDR_OPT1);
  wire       sel_opt   = sel_opt0 | sel_opt1;
  wire       sel_ctrl  = (avm_i.address == obcd_pkg::ADDR_CTRL);
  wire       sel_stat  = (avm_i.address == obcd_pkg::ADDR_STAT);
  wire       in_acc    = (state_q == ST_ACC);
  wire       wr_lane0  = avm_i.write & avm_i.byteenable[0];

  // option writes and erase outside programming mode or under write protect are refused
  wire       opt_wr_try = in_acc & wr_lane0 & sel_opt;
  wire       opt_wr_ok  = opt_wr_try & prog_mode_i & ~wp_stored;
  wire       erase_try  = in_acc & wr_lane0 & sel_ctrl & avm_i.writedata[obcd_pkg::CTRL_ERASE];
  wire       erase_ok   = erase_try & prog_mode_i & ~wp_stored;
  wire       refuse_now = (opt_wr_try & ~opt_wr_ok) | (erase_try & ~erase_ok);
  wire       refuse_clr = in_acc & wr_lane0 & sel_ctrl
                          & avm_i.writedata[obcd_pkg::CTRL_CLR_REFUS];

  // store port: load walk, bus access, or erase to delivered values
  wire       in_oerase = (state_q == ST_OERASE0) | (state_q == ST_OERASE1);
  wire       mem_addr  = (state_q == ST_LOAD0)   ? 1'b0 :
                         (state_q == ST_LOAD1)   ? 1'b1 :
                         (state_q == ST_OERASE0) ? 1'b0 :
                         (state_q == ST_OERASE1) ? 1'b1 : sel_opt1;
  wire       mem_we    = opt_wr_ok | in_oerase;
  wire [7:0] erase_val = mem_addr ? obcd_pkg::OPT1_DEFAULT : obcd_pkg::OPT0_DEFAULT;
  wire [7:0] mem_wdata = in_oerase ? erase_val : avm_i.writedata[7:0];

  // configuration sanity flags kept by the programming party
  wire [7:0] ld1       = mem_rdata;
  wire [2:0] ld_range  = act0[obcd_pkg::B0_RANGE_LSB +: 3];
  wire       bad_rsvd  = ~ld1[obcd_pkg::B1_RSVD];
  wire       bad_wake  = ~act0[obcd_pkg::B0_WAKE] & (ld_range != obcd_pkg::RANGE_VLP);
  wire       rc_start  = (ld1[obcd_pkg::B1_STARTUP_CLOCK_SELECT_LSB +: 2] == obcd_pkg::CLK_INT_RC);
  wire       bad_rc    = rc_start & (ld_range != obcd_pkg::OPT0_DEFAULT[6:4]);

  // halt reset only while a watchdog runs, hardware or software enabled
  wire       wdg_active = cfg_o.watchdog_hw_on | sw_wdg_enable_i;
  wire       next_halt  = halt_entry_i & cfg_o.watchdog_reset_on_halt & wdg_active;

  obcd_nvstore u_store (
    .ref_clk_i (ref_clk_i),
    .por_b_i   (por_b_i),
    .addr_i    (mem_addr),
    .we_i      (mem_we),
    .wdata_i   (mem_wdata),
    .rdata_o   (mem_rdata)
  );

  // sequencer: load after reset, then serve the bus and erase requests
  always_comb begin
    next_state = state_q;
    case (state_q)
      ST_LOAD0:   next_state = ST_LOAD1;
      ST_LOAD1:   next_state = ST_LOAD2;
      ST_LOAD2:   next_state = ST_IDLE;
      ST_IDLE:    if (req_any) next_state = ST_ACC;
      ST_ACC:     next_state = ST_RESP;
      ST_RESP: begin
        if (erase_pend && rdp_stored) next_state = ST_MERASE;
        else if (erase_pend) next_state = ST_OERASE0;
        else next_state = ST_IDLE;
      end
      ST_MERASE:  if (mass_erase_done_i) next_state = ST_OERASE0;
      ST_OERASE0: next_state = ST_OERASE1;
      ST_OERASE1: next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  // read data mux; option bytes read as zero outside programming mode
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel_opt) begin
      if (prog_mode_i) next_readdata = {24'h00_0000, mem_rdata};
    end else if (sel_stat) begin
      next_readdata[obcd_pkg::STAT_REFUSED]         = refused;
      next_readdata[obcd_pkg::STAT_WP]              = wp_stored;
      next_readdata[obcd_pkg::STAT_RDP]             = rdp_stored;
      next_readdata[obcd_pkg::STAT_WARN]            = warn;
      next_readdata[obcd_pkg::STAT_ACT0_LSB +: 8]   = act0;
      next_readdata[obcd_pkg::STAT_ACT1_LSB +: 8]   = act1;
    end else if (sel_ctrl) begin
      next_readdata = 32'h0000_0000; // command bits are self-clearing
    end else begin
      next_readdata = 32'h0000_0000; // unmapped reads as zero
    end
  end

  // state and bus handshake; waitrequest drops for one cycle per request
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q           <= ST_LOAD0;
      avm_waitrequest_o <= 1'b1;
      avm_readdata_o    <= 32'h0000_0000;
      erase_pend        <= 1'b0;
      mass_erase_req_o  <= 1'b0;
    end else begin
      state_q           <= next_state;
      avm_waitrequest_o <= ~in_acc;
      if (in_acc) avm_readdata_o <= avm_i.read ? next_readdata : 32'h0000_0000;
      if (in_acc) erase_pend <= erase_ok;
      else if (state_q == ST_RESP) erase_pend <= 1'b0;
      mass_erase_req_o  <= (next_state == ST_MERASE);
    end
  end

  // settings latch: taken once after reset, then frozen
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act0  <= obcd_pkg::OPT0_DEFAULT;
      act1  <= obcd_pkg::OPT1_DEFAULT;
      cfg_o <= obcd_pkg::CFG_RESET;
      warn  <= 1'b0;
    end else begin
      if (state_q == ST_LOAD1) act0 <= mem_rdata;
      if (state_q == ST_LOAD2) begin
        act1  <= mem_rdata;
        cfg_o <= obcd_pkg::decode_cfg(act0, mem_rdata);
        warn  <= bad_rsvd | bad_wake | bad_rc;
      end
    end
  end

  // live copy of the stored protection bits; write protect never clears
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_stored  <= 1'b0;
      rdp_stored <= 1'b0;
    end else if (state_q == ST_LOAD1) begin
      wp_stored  <= mem_rdata[obcd_pkg::B0_WRP];
      rdp_stored <= mem_rdata[obcd_pkg::B0_RDP];
    end else if (opt_wr_ok && sel_opt0) begin
      wp_stored  <= avm_i.writedata[obcd_pkg::B0_WRP];
      rdp_stored <= avm_i.writedata[obcd_pkg::B0_RDP];
    end else if (state_q == ST_OERASE0) begin
      wp_stored  <= 1'b0;
      rdp_stored <= 1'b0;
    end
  end

  // sticky refusal flag, a new refusal wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refused <= 1'b0;
    end else if (refuse_now) begin
      refused <= 1'b1;
    end else if (refuse_clr) begin
      refused <= 1'b0;
    end
  end

  // halt reset pulse and erase fill pattern
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halt_reset_o <= 1'b0;
      erase_fill_o <= obcd_pkg::PROG_FILL;
    end else begin
      halt_reset_o <= next_halt;
      erase_fill_o <= obcd_pkg::PROG_FILL;
    end
  end

  // checks on the running logic
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_cfg_hold_stable: assert property (
    (state_q != ST_LOAD2) |=> $stable(cfg_o))
    else $error("settings changed outside the load");

  a_opt_locked_run: assert property (
    (in_acc && !prog_mode_i && sel_opt) |-> !mem_we)
    else $error("option byte written outside programming mode");

  a_opt_read_blank: assert property (
    (in_acc && !prog_mode_i && sel_opt && avm_i.read) |=> (avm_readdata_o == 32'h0000_0000))
    else $error("option byte visible outside programming mode");

  a_startup_rc_default: assert property (
    (state_q == ST_LOAD1) |-> (cfg_o.startup_clock_select == obcd_pkg::CLK_INT_RC))
    else $error("startup clock not internal rc before load");

  a_clock_pll_decode: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.startup_clock_select == act1[7:6])
      && (cfg_o.fast_pll_bypass == act1[4]) && (cfg_o.pll_enable == !act1[4]))
    else $error("clock or pll setting misdecoded");

  a_lvd_decode: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.lvd_enable == (act1[3:2] != 2'h3)))
    else $error("lvd enable misdecoded");

  a_halt_reset_on: assert property (
    (halt_entry_i && cfg_o.watchdog_reset_on_halt && cfg_o.watchdog_hw_on) |=> halt_reset_o)
    else $error("missing reset on halt");

  a_halt_reset_off: assert property (
    !cfg_o.watchdog_reset_on_halt |=> !halt_reset_o)
    else $error("reset on halt while disabled");

  a_wp_refuse: assert property (
    wp_stored |-> !mem_we)
    else $error("store modified under write protect");

  a_erase_first: assert property (
    (state_q == ST_RESP && erase_pend && rdp_stored)
      |=> mass_erase_req_o ##0 (state_q == ST_MERASE) ##0 !mem_we)
    else $error("option erase before memory erase");

  a_readout_block: assert property (
    cfg_o.readout_protect |-> cfg_o.prog_write_block)
    else $error("readout protect leaves flash writable");

  // decoded fields against the raw latched bytes, one field per check, two in a_range_applies
  a_lvd_level: assert property (
    (state_q == ST_LOAD2)
      |=> (cfg_o.low_voltage_detect_level == act1[obcd_pkg::B1_LVD_LSB +: 2]))
    else $error("lvd level misdecoded");

  a_wdg_type_decode: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.watchdog_hw_on == !act1[obcd_pkg::B1_WDG_TYPE]))
    else $error("watchdog type misdecoded");

  a_wake_decode: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.wakeup_clock_select == act0[obcd_pkg::B0_WAKE]))
    else $error("wakeup clock misdecoded");

  a_range_applies: assert property (
    (state_q == ST_LOAD2)
      |=> (cfg_o.range_applies == act1[obcd_pkg::B1_STARTUP_CLOCK_SELECT_LSB + 1])
      && (cfg_o.oscillator_range == act0[obcd_pkg::B0_RANGE_LSB +: 3]))
    else $error("oscillator range misdecoded");

  a_ext_main_pin: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.ext_clk_main_pin == (act1[obcd_pkg::B1_STARTUP_CLOCK_SELECT_LSB + 1]
      && (act0[obcd_pkg::B0_RANGE_LSB +: 3] == obcd_pkg::RANGE_EXT_MAIN))))
    else $error("main clock pin select misdecoded");

  a_ext_alt_pin: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.ext_clk_alt_pin == (act1[obcd_pkg::B1_STARTUP_CLOCK_SELECT_LSB + 1]
      && (act0[obcd_pkg::B0_RANGE_LSB +: 3] == obcd_pkg::RANGE_EXT_ALT))))
    else $error("alternate clock pin select misdecoded");

  a_range_reserved: assert property (
    (state_q == ST_LOAD2)
      |=> (cfg_o.range_reserved == (act0[obcd_pkg::B0_RANGE_LSB +: 3] == obcd_pkg::RANGE_RSVD)))
    else $error("reserved range code missed");

  a_sector_size: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.boot_sector_bytes
      == (obcd_pkg::SECT_BASE_BYTE << act0[obcd_pkg::B0_SECT_LSB +: 2])))
    else $error("boot sector size misdecoded");

  a_rdp_decode: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.readout_protect == act0[obcd_pkg::B0_RDP]))
    else $error("readout protect misdecoded");

  a_wrp_decode: assert property (
    (state_q == ST_LOAD2) |=> (cfg_o.flash_write_protect == act0[obcd_pkg::B0_WRP]))
    else $error("write protect misdecoded");

  // the software-enabled watchdog path is easy to drop, so it gets its own pair
  a_halt_sw_on: assert property (
    (halt_entry_i && cfg_o.watchdog_reset_on_halt && sw_wdg_enable_i) |=> halt_reset_o)
    else $error("missing reset on halt with software watchdog");

  a_halt_no_wdg: assert property (
    (halt_entry_i && !cfg_o.watchdog_hw_on && !sw_wdg_enable_i) |=> !halt_reset_o)
    else $error("reset on halt with no watchdog running");

  a_opt_refused: assert property (
    (opt_wr_try && !prog_mode_i) |=> refused)
    else $error("option write outside programming mode not flagged");

  a_erase_refused: assert property (
    (erase_try && wp_stored) |=> (refused && !erase_pend))
    else $error("erase accepted under write protect");

  a_wp_sticky: assert property (
    wp_stored |=> wp_stored)
    else $error("write protect cleared without reset");

  a_merase_wait: assert property (
    (state_q == ST_MERASE && !mass_erase_done_i)
      |=> (state_q == ST_MERASE && mass_erase_req_o))
    else $error("memory erase abandoned before done");

endmodule

// *** tb/obcd_prog_tool.sv ***
// programming tool model: avalon master that writes and reads the option bytes
`timescale 1ns/100ps
module obcd_prog_tool (
  // clock
  input  wire logic               ref_clk_i,
  // avalon master side
  output obcd_pkg::obcd_avm_req_s avm_o,
  input  wire logic        [31:0] avm_readdata_i,
  input  wire logic               avm_waitrequest_i
);
  // bus idle from time zero
  initial begin
    avm_o = '0;
  end

  // one transfer: hold the request until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk_i);
    avm_o <= '{read: ~wr, write: wr, address: adr, writedata: wd, byteenable: 4'hF};
    do @(posedge ref_clk_i); while (avm_waitrequest_i !== 1'b0);
    rd = avm_readdata_i;
    avm_o <= '0;
  endtask

  // the tool fixes up bits the device leaves to it before writing both bytes
  task automatic prog_opt(input logic [7:0] b0, input logic [7:0] b1);
    logic [31:0] d;
    b1[5] = 1'b1;
    if (!b0[7]) b0[6:4] = obcd_pkg::RANGE_VLP;
    if (b1[7:6] == 2'h0) b0[6:4] = 3'h7;
    xfer(1'b1, obcd_pkg::ADDR_OPT0, {24'h0, b0}, d);
    xfer(1'b1, obcd_pkg::ADDR_OPT1, {24'h0, b1}, d);
  endtask
endmodule

// *** tb/option_byte_config_decoder_tb_top.sv ***
// testbench top: programs option bytes, resets and checks decoded settings
`timescale 1ns/100ps
module option_byte_config_decoder_tb_top;
  logic                    ref_clk_i, rst_b_i, por_b_i, prog_mode_i;
  logic                    halt_entry_i, sw_wdg_enable_i, mass_erase_done_i;
  obcd_pkg::obcd_avm_req_s avm;
  logic             [31:0] rdata;
  logic                    wait_req, halt_rst, erase_req, saw_erase;
  obcd_pkg::obcd_cfg_s     cfg;
  logic              [7:0] fill;
  int                      errors, checked, cycles;

  // 40 MHz core clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  obcd_top dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i),
    .avm_i(avm), .avm_readdata_o(rdata), .avm_waitrequest_o(wait_req),
    .prog_mode_i(prog_mode_i), .halt_entry_i(halt_entry_i),
    .sw_wdg_enable_i(sw_wdg_enable_i), .mass_erase_done_i(mass_erase_done_i),
    .cfg_o(cfg), .halt_reset_o(halt_rst), .mass_erase_req_o(erase_req),
    .erase_fill_o(fill)
  );

  obcd_prog_tool tool (
    .ref_clk_i(ref_clk_i), .avm_o(avm), .avm_readdata_i(rdata),
    .avm_waitrequest_i(wait_req)
  );

  // memory side: erase finishes one cycle after it is asked for
  always @(posedge ref_clk_i) begin
    mass_erase_done_i <= erase_req;
    if (erase_req === 1'b1) saw_erase <= 1'b1;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // por also restores the delivered bytes; plain reset only reloads settings
  task automatic do_reset(input logic por);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    por_b_i <= ~por;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    por_b_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
  endtask

  // expected settings worked out bit by bit from the two bytes
  task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1);
    chk("startup clock", b1[7:6], cfg.startup_clock_select);
    chk("pll", {b1[4], ~b1[4]}, {cfg.fast_pll_bypass, cfg.pll_enable});
    chk("lvd", {b1[3:2] != 2'h3, b1[3:2]}, {cfg.lvd_enable, cfg.low_voltage_detect_level});
    chk("wdg", {b1[1], ~b1[1]}, {cfg.watchdog_type_select, cfg.watchdog_hw_on});
    chk("halt rst opt", b1[0], cfg.watchdog_reset_on_halt);
    chk("wake clk", b0[7], cfg.wakeup_clock_select);
    chk("range", {b1[7], b0[6:4]}, {cfg.range_applies, cfg.oscillator_range});
    chk("ext pins", {b1[7] && b0[6:4] == 3'h5, b1[7] && b0[6:4] == 3'h7, b0[6:4] == 3'h6},
        {cfg.ext_clk_main_pin, cfg.ext_clk_alt_pin, cfg.range_reserved});
    chk("sector", 32'h200 << b0[3:2], cfg.boot_sector_bytes);
    chk("rdp", b0[1], cfg.readout_protect);
    chk("wrp", b0[0], cfg.flash_write_protect);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [1:0]  ck;
    logic [7:0]  b0, b1;
    logic [31:0] q;
    rst_b_i = 1'b0;
    por_b_i = 1'b0;
    prog_mode_i = 1'b0;
    halt_entry_i = 1'b0;
    sw_wdg_enable_i = 1'b0;
    mass_erase_done_i = 1'b0;
    saw_erase = 1'b0;
    errors = 0;
    checked = 0;
    cycles = 0;
    do_reset(1'b1);
    check_cfg(8'hFC, 8'h3F);
    chk("erase fill", 8'hFF, fill);
    // option bytes are closed outside programming mode
    tool.xfer(1'b1, obcd_pkg::ADDR_OPT1, 32'h0, q);
    tool.xfer(1'b0, obcd_pkg::ADDR_OPT0, 32'h0, q);
    chk("opt0 outside prog", 32'h0, q);
    tool.xfer(1'b0, obcd_pkg::ADDR_STAT, 32'h0, q);
    chk("refused flag", 1'b1, q[0]);
    // clearing the flag leaves only the latched delivered bytes in status
    tool.xfer(1'b1, obcd_pkg::ADDR_CTRL, 32'h2, q);
    tool.xfer(1'b0, obcd_pkg::ADDR_STAT, 32'h0, q);
    chk("status after clear", 32'h3FFC_0000, q);
    prog_mode_i <= 1'b1;
    // every clock, lvd, range and sector code, settings applied by reset
    for (int i = 0; i < 8; i++) begin
      ck = (i == 7) ? 2'h0 : 2'(i % 3 + 1);
      b1 = {ck, 1'b1, i[2], i[1:0], i[0], i[1]};
      b0 = {i != 4, 3'(i), 2'(i), 2'h0};
      tool.prog_opt(b0, b1);
      tool.xfer(1'b0, obcd_pkg::ADDR_OPT1, 32'h0, q);
      chk("opt1 readback", b1, q[7:0]);
      do_reset(1'b0);
      check_cfg(b0, b1);
      @(posedge ref_clk_i);
      sw_wdg_enable_i <= i[2];
      halt_entry_i <= 1'b1;
      @(posedge ref_clk_i);
      halt_entry_i <= 1'b0;
      @(posedge ref_clk_i);
      chk("halt reset", b1[0] & (~b1[1] | i[2]), halt_rst);
    end
    // new bytes do not reach the settings before the next reset
    tool.prog_opt(8'hFC, 8'h3F);
    check_cfg(b0, b1);
    // erasing the options under readout protect erases memory first
    tool.prog_opt(8'hFE, 8'hFF);
    do_reset(1'b0);
    chk("rdp blocks writes", 1'b1, cfg.prog_write_block);
    tool.xfer(1'b1, obcd_pkg::ADDR_CTRL, 32'h1, q);
    tool.xfer(1'b0, obcd_pkg::ADDR_OPT0, 32'h0, q);
    chk("memory erase seen", 1'b1, saw_erase);
    chk("opt0 after erase", 8'hFC, q[7:0]);
    // write protect is permanent: writes and erase refused across resets
    tool.prog_opt(8'hFD, 8'hFF);
    do_reset(1'b0);
    chk("wrp set", 1'b1, cfg.flash_write_protect);
    saw_erase <= 1'b0;
    tool.xfer(1'b1, obcd_pkg::ADDR_OPT0, 32'hFC, q);
    tool.xfer(1'b1, obcd_pkg::ADDR_CTRL, 32'h1, q);
    // byte 1 write was refused too, so the erased byte 1 stays latched
    tool.xfer(1'b0, obcd_pkg::ADDR_STAT, 32'h0, q);
    chk("status under wrp", 32'h3FFD_0003, q);
    do_reset(1'b0);
    tool.xfer(1'b0, obcd_pkg::ADDR_OPT0, 32'h0, q);
    chk("opt0 kept", 8'hFD, q[7:0]);
    chk("no erase", 1'b0, saw_erase);
    chk("wrp kept", 1'b1, cfg.flash_write_protect);
    tally_and_finish();
  end
endmodule
